/* File: core/burst_buffer.sv */
// small word store holding one burst between source read and destination write
`timescale 1ns/1ps
module burst_buffer (
	input  wire logic                                 clk,
	input  wire logic                                 ce,
	input  wire logic                                 wr_en,
	input  wire logic [move_engine_pkg::BURST_W-2:0]  wr_addr,
	input  wire logic [move_engine_pkg::DATA_W-1:0]   wr_data,
	input  wire logic [move_engine_pkg::BURST_W-2:0]  rd_addr,
	output logic      [move_engine_pkg::DATA_W-1:0]   rd_data
);

	logic [move_engine_pkg::DATA_W-1:0] mem [0:3];

	always_ff @(posedge clk) begin
		if (ce) begin
			if (wr_en) begin
				mem[wr_addr] <= wr_data;
			end
			// write-through, so a one-word burst reads back its own word
			if (wr_en && (wr_addr == rd_addr)) begin
				rd_data <= wr_data;
			end else begin
				rd_data <= mem[rd_addr];
			end
		end
	end

endmodule

/* File: core/memory_move_engine.sv */
// memory-to-memory move instruction engine
// Notes on behaviour
// (RQ1) top two bits of word one mark a memory move
// (RQ2) nonzero bits 29..24 raise illegal instruction
// (RQ3) byte count is the low 24 bits of word one
// (RQ4) moves may copy internal register values to or from memory
// (RQ5) register-space address selects register by low six bits
// (RQ6) first_byte_received ignores writes from a move
// (RQ7) first_byte_received loads only via internal register instructions
// (RQ8) register accesses obey the same alignment checks
// (RQ9) differing low two address bits raise illegal instruction
// (RQ10) burst from source into fifo, write out, until count zero
// (RQ11) temporary stack and data_structure_base are overwritten
// (RQ12) only direct addresses; no indirection
// (RQ13) word two is source, word three destination
`timescale 1ns/1ps
module memory_move_engine (
	input  wire logic                                   clk,
	input  wire logic                                   reset_n,
	input  wire logic                                   ce,
	input  wire logic                                   instr_valid,
	input  wire logic [move_engine_pkg::DATA_W-1:0]     instr_word,
	output logic                                        instr_ready,
	input  wire logic [move_engine_pkg::ADDR_W-1:0]     reg_base,
	output logic                                        mem_req,
	output logic                                        mem_we,
	output logic      [move_engine_pkg::ADDR_W-1:0]     mem_addr,
	output logic      [move_engine_pkg::DATA_W-1:0]     mem_wdata,
	input  wire logic                                   mem_ack,
	input  wire logic [move_engine_pkg::DATA_W-1:0]     mem_rdata,
	output logic                                        reg_we,
	output logic      [move_engine_pkg::REG_SEL_W-1:0]  reg_sel,
	output logic      [move_engine_pkg::DATA_W-1:0]     reg_wdata,
	input  wire logic [move_engine_pkg::DATA_W-1:0]     reg_rdata,
	input  wire logic                                   fbr_load,
	input  wire logic [7:0]                             fbr_data,
	output logic      [7:0]                             fbr_value,
	output logic      [move_engine_pkg::DATA_W-1:0]     temp_value,
	output logic      [move_engine_pkg::DATA_W-1:0]     dsb_value,
	output logic                                        busy,
	output logic                                        done,
	output logic                                        illegal_instr
);

	// ****************************************************************
	// state
	// ****************************************************************
	move_engine_pkg::state_type                 state_r, state_nxt;
	logic [move_engine_pkg::COUNT_W-1:0]        count_r, count_nxt;
	logic [move_engine_pkg::ADDR_W-1:0]         src_r, src_nxt;
	logic [move_engine_pkg::ADDR_W-1:0]         dst_r, dst_nxt;
	logic [move_engine_pkg::BURST_W-1:0]        fill_r, fill_nxt;
	logic [move_engine_pkg::BURST_W-1:0]        drain_r, drain_nxt;
	logic                                       rsvd_bad_r, rsvd_bad_nxt;
	logic [7:0]                                 fbr_r, fbr_nxt;
	logic                                       instr_ready_nxt, mem_req_nxt, mem_we_nxt;
	logic [move_engine_pkg::ADDR_W-1:0]         mem_addr_nxt;
	logic [move_engine_pkg::DATA_W-1:0]         mem_wdata_nxt, reg_wdata_nxt;
	logic                                       reg_we_nxt, done_nxt, illegal_nxt;
	logic [move_engine_pkg::REG_SEL_W-1:0]      reg_sel_nxt;

	logic                                       buf_we;
	logic [move_engine_pkg::DATA_W-1:0]         buf_wdata, buf_rdata;
	logic                                       src_is_reg, dst_is_reg;

	// chip select: upper address bits match the register window
	assign src_is_reg = (src_r[move_engine_pkg::ADDR_W-1:move_engine_pkg::REG_SEL_W] ==
		reg_base[move_engine_pkg::ADDR_W-1:move_engine_pkg::REG_SEL_W]); // [RQ5]
	assign dst_is_reg = (dst_r[move_engine_pkg::ADDR_W-1:move_engine_pkg::REG_SEL_W] ==
		reg_base[move_engine_pkg::ADDR_W-1:move_engine_pkg::REG_SEL_W]); // [RQ5]

	burst_buffer u_buf (
		.clk     (clk),
		.ce      (ce),
		.wr_en   (buf_we),
		.wr_addr (fill_r[move_engine_pkg::BURST_W-2:0]),
		.wr_data (buf_wdata),
		.rd_addr (drain_nxt[move_engine_pkg::BURST_W-2:0]),
		.rd_data (buf_rdata)
	);

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		state_nxt       = state_r;
		count_nxt       = count_r;
		src_nxt         = src_r;
		dst_nxt         = dst_r;
		fill_nxt        = fill_r;
		drain_nxt       = drain_r;
		rsvd_bad_nxt    = rsvd_bad_r;
		fbr_nxt         = fbr_r;
		instr_ready_nxt = 1'b0;
		mem_req_nxt     = 1'b0;
		mem_we_nxt      = 1'b0;
		mem_addr_nxt    = mem_addr;
		mem_wdata_nxt   = mem_wdata;
		reg_we_nxt      = 1'b0;
		reg_sel_nxt     = reg_sel;
		reg_wdata_nxt   = reg_wdata;
		done_nxt        = 1'b0;
		illegal_nxt     = 1'b0;
		buf_we          = 1'b0;
		buf_wdata       = mem_rdata;
		// only the internal register instruction path loads this byte
		if (fbr_load) begin
			fbr_nxt = fbr_data; // [RQ7]
		end
		case (state_r)
			move_engine_pkg::ST_IDLE: begin
				instr_ready_nxt = 1'b1;
				if (instr_valid && instr_ready) begin
					if (instr_word[move_engine_pkg::TYPE_HI:move_engine_pkg::TYPE_LO] ==
						move_engine_pkg::TYPE_MOVE) begin // [RQ1]
						count_nxt    = instr_word[move_engine_pkg::COUNT_HI:move_engine_pkg::COUNT_LO]; // [RQ3]
						rsvd_bad_nxt = (instr_word[move_engine_pkg::RSVD_HI:move_engine_pkg::RSVD_LO] !=
							move_engine_pkg::RSVD_ZERO); // [RQ2]
						state_nxt    = move_engine_pkg::ST_SRC;
					end
				end
			end
			move_engine_pkg::ST_SRC: begin
				instr_ready_nxt = 1'b1;
				if (instr_valid && instr_ready) begin
					src_nxt         = instr_word; // [RQ13] [RQ12] taken as a direct address
					state_nxt       = move_engine_pkg::ST_DST;
				end
			end
			move_engine_pkg::ST_DST: begin
				if (instr_valid && instr_ready) begin
					dst_nxt         = instr_word; // [RQ13]
					instr_ready_nxt = 1'b0;
					state_nxt       = move_engine_pkg::ST_CHECK;
				end else begin
					instr_ready_nxt = 1'b1;
				end
			end
			move_engine_pkg::ST_CHECK: begin
				// alignment applies to register windows too
				if (rsvd_bad_r || (src_r[1:0] != dst_r[1:0])) begin // [RQ2] [RQ9] [RQ8]
					state_nxt = move_engine_pkg::ST_FAULT;
				end else if (count_r == move_engine_pkg::ZERO_COUNT) begin
					state_nxt = move_engine_pkg::ST_DONE;
				end else begin
					fill_nxt  = move_engine_pkg::ZERO_BURST;
					state_nxt = move_engine_pkg::ST_READ;
				end
			end
			move_engine_pkg::ST_READ: begin
				if (src_is_reg) begin
					// register source read straight from the internal file
					buf_we    = 1'b1; // [RQ4] [RQ5]
					buf_wdata = (src_r[move_engine_pkg::REG_SEL_W-1:0] == move_engine_pkg::FBR_SEL) ?
						{24'h00_0000, fbr_r} : reg_rdata;
					reg_sel_nxt = src_r[move_engine_pkg::REG_SEL_W-1:0];
					fill_nxt  = fill_r + 3'h1;
					src_nxt   = src_r + move_engine_pkg::WORD_BYTES;
					count_nxt = (count_r > move_engine_pkg::WORD_COUNT) ?
						count_r - move_engine_pkg::WORD_COUNT : move_engine_pkg::ZERO_COUNT;
					if (fill_nxt == move_engine_pkg::BURST_WORDS || count_nxt == move_engine_pkg::ZERO_COUNT) begin
						drain_nxt = move_engine_pkg::ZERO_BURST;
						state_nxt = move_engine_pkg::ST_WRITE;
					end
				end else begin
					mem_req_nxt  = 1'b1;
					mem_addr_nxt = src_r;
					state_nxt    = move_engine_pkg::ST_RWAIT;
				end
			end
			move_engine_pkg::ST_RWAIT: begin
				mem_req_nxt = !mem_ack;
				if (mem_ack) begin
					buf_we    = 1'b1; // [RQ10]
					fill_nxt  = fill_r + 3'h1;
					src_nxt   = src_r + move_engine_pkg::WORD_BYTES;
					count_nxt = (count_r > move_engine_pkg::WORD_COUNT) ?
						count_r - move_engine_pkg::WORD_COUNT : move_engine_pkg::ZERO_COUNT;
					if (fill_nxt == move_engine_pkg::BURST_WORDS || count_nxt == move_engine_pkg::ZERO_COUNT) begin
						drain_nxt = move_engine_pkg::ZERO_BURST;
						state_nxt = move_engine_pkg::ST_WRITE;
					end else begin
						state_nxt = move_engine_pkg::ST_READ;
					end
				end
			end
			move_engine_pkg::ST_WRITE: begin
				if (dst_is_reg) begin
					// writes aimed at the first-byte register are dropped
					reg_sel_nxt   = dst_r[move_engine_pkg::REG_SEL_W-1:0];
					reg_wdata_nxt = buf_rdata;
					reg_we_nxt    = (dst_r[move_engine_pkg::REG_SEL_W-1:0] != move_engine_pkg::FBR_SEL); // [RQ6] [RQ4]
					dst_nxt       = dst_r + move_engine_pkg::WORD_BYTES;
					drain_nxt     = drain_r + 3'h1;
					if (drain_nxt == fill_r) begin
						state_nxt = (count_r == move_engine_pkg::ZERO_COUNT) ? move_engine_pkg::ST_DONE :
							move_engine_pkg::ST_CHECK;
					end
				end else begin
					mem_req_nxt   = 1'b1;
					mem_we_nxt    = 1'b1;
					mem_addr_nxt  = dst_r;
					mem_wdata_nxt = buf_rdata;
					state_nxt     = move_engine_pkg::ST_WWAIT;
				end
			end
			move_engine_pkg::ST_WWAIT: begin
				mem_req_nxt = !mem_ack;
				mem_we_nxt  = !mem_ack;
				if (mem_ack) begin
					dst_nxt   = dst_r + move_engine_pkg::WORD_BYTES;
					drain_nxt = drain_r + 3'h1;
					if (drain_nxt == fill_r) begin // [RQ10]
						state_nxt = (count_r == move_engine_pkg::ZERO_COUNT) ? move_engine_pkg::ST_DONE :
							move_engine_pkg::ST_CHECK;
					end else begin
						state_nxt = move_engine_pkg::ST_WRITE;
					end
				end
			end
			move_engine_pkg::ST_DONE: begin
				done_nxt  = 1'b1;
				state_nxt = move_engine_pkg::ST_IDLE;
			end
			move_engine_pkg::ST_FAULT: begin
				illegal_nxt = 1'b1;
				state_nxt   = move_engine_pkg::ST_IDLE;
			end
			default: begin
				state_nxt = move_engine_pkg::ST_IDLE;
			end
		endcase
	end

	// ****************************************************************
	// registers
	// ****************************************************************
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			state_r       <= move_engine_pkg::ST_IDLE;
			count_r       <= move_engine_pkg::ZERO_COUNT;
			src_r         <= move_engine_pkg::ZERO_ADDR;
			dst_r         <= move_engine_pkg::ZERO_ADDR;
			fill_r        <= move_engine_pkg::ZERO_BURST;
			drain_r       <= move_engine_pkg::ZERO_BURST;
			rsvd_bad_r    <= 1'b0;
			fbr_r         <= 8'h00;
			instr_ready   <= 1'b0;
			mem_req       <= 1'b0;
			mem_we        <= 1'b0;
			mem_addr      <= move_engine_pkg::ZERO_ADDR;
			mem_wdata     <= move_engine_pkg::ZERO_DATA;
			reg_we        <= 1'b0;
			reg_sel       <= 6'h00;
			reg_wdata     <= move_engine_pkg::ZERO_DATA;
			done          <= 1'b0;
			illegal_instr <= 1'b0;
			busy          <= 1'b0;
			fbr_value     <= 8'h00;
			temp_value    <= move_engine_pkg::ZERO_DATA;
			dsb_value     <= move_engine_pkg::ZERO_DATA;
		end else if (ce) begin
			state_r       <= state_nxt;
			count_r       <= count_nxt;
			src_r         <= src_nxt;
			dst_r         <= dst_nxt;
			fill_r        <= fill_nxt;
			drain_r       <= drain_nxt;
			rsvd_bad_r    <= rsvd_bad_nxt;
			fbr_r         <= fbr_nxt;
			instr_ready   <= instr_ready_nxt && (state_nxt == state_r || state_nxt == move_engine_pkg::ST_SRC ||
				state_nxt == move_engine_pkg::ST_DST);
			mem_req       <= mem_req_nxt;
			mem_we        <= mem_we_nxt;
			mem_addr      <= mem_addr_nxt;
			mem_wdata     <= mem_wdata_nxt;
			reg_we        <= reg_we_nxt;
			reg_sel       <= reg_sel_nxt;
			reg_wdata     <= reg_wdata_nxt;
			done          <= done_nxt;
			illegal_instr <= illegal_nxt;
			busy          <= (state_nxt != move_engine_pkg::ST_IDLE);
			fbr_value     <= fbr_nxt;
			// working copies; previous contents are lost by design
			temp_value    <= src_nxt; // [RQ11]
			dsb_value     <= dst_nxt; // [RQ11]
		end
	end

endmodule

/* File: core/move_engine_pkg.sv */
// constants and types shared by the memory move engine
package move_engine_pkg;

	localparam int ADDR_W          = 32;
	localparam int DATA_W          = 32;
	localparam int COUNT_W         = 24;
	localparam int REG_SEL_W       = 6;
	localparam int BURST_W         = 3;

	localparam int TYPE_HI         = 31;
	localparam int TYPE_LO         = 30;
	localparam int RSVD_HI         = 29;
	localparam int RSVD_LO         = 24;
	localparam int COUNT_HI        = 23;
	localparam int COUNT_LO        = 0;

	localparam logic [1:0] TYPE_MOVE      = 2'h3;
	localparam logic [5:0] RSVD_ZERO      = 6'h00;
	localparam logic [REG_SEL_W-1:0] FBR_SEL  = 6'h08;
	localparam logic [REG_SEL_W-1:0] TEMP_SEL = 6'h1C;
	localparam logic [REG_SEL_W-1:0] DSB_SEL  = 6'h10;

	localparam logic [BURST_W-1:0] BURST_WORDS = 3'h4;
	localparam logic [ADDR_W-1:0]  WORD_BYTES  = 32'h0000_0004;
	localparam logic [COUNT_W-1:0] WORD_COUNT  = 24'h00_0004;
	localparam logic [ADDR_W-1:0]  ZERO_ADDR   = 32'h0000_0000;
	localparam logic [DATA_W-1:0]  ZERO_DATA   = 32'h0000_0000;
	localparam logic [COUNT_W-1:0] ZERO_COUNT  = 24'h00_0000;
	localparam logic [BURST_W-1:0] ZERO_BURST  = 3'h0;

	typedef enum logic [3:0] {
		ST_IDLE   = 4'b0000,
		ST_SRC    = 4'b0001,
		ST_DST    = 4'b0010,
		ST_CHECK  = 4'b0011,
		ST_READ   = 4'b0100,
		ST_RWAIT  = 4'b0101,
		ST_WRITE  = 4'b0110,
		ST_WWAIT  = 4'b0111,
		ST_DONE   = 4'b1000,
		ST_FAULT  = 4'b1001
	} state_type;

endpackage

/* File: dv/mem_model.sv */
// behavioural system memory answering the engine's bus requests
`timescale 1ns/1ps
module mem_model (
	input  wire logic        clk,
	input  wire logic        slow,
	input  wire logic        mem_req,
	input  wire logic        mem_we,
	input  wire logic [31:0] mem_addr,
	input  wire logic [31:0] mem_wdata,
	output logic             mem_ack,
	output logic      [31:0] mem_rdata
);
	// ************
	// memory model
	// ************
	logic [31:0] wr_mem [logic [31:0]];
	int          wait_n = 0;
	initial mem_ack = 1'b0;
	initial mem_rdata = 32'h0000_0000;
	// read data toggles outside an ack so a stale value never looks valid
	always @(posedge clk) begin
		mem_ack <= 1'b0;
		mem_rdata <= ~mem_rdata;
		if (mem_req && !mem_ack) begin
			if (wait_n < (slow ? 3 : 0)) begin
				wait_n <= wait_n + 1;
			end else begin
				wait_n <= 0;
				mem_ack <= 1'b1;
				if (mem_we) wr_mem[mem_addr] = mem_wdata;
				else mem_rdata <= mem_addr ^ 32'h5A5A_C3C3;
			end
		end
	end
endmodule

/* File: dv/memory_move_engine_properties.sv */
// assertion checker on the memory move engine ports
`timescale 1ns/1ps
module memory_move_engine_properties (
	input wire logic        clk,
	input wire logic        reset_n,
	input wire logic        ce,
	input wire logic        instr_valid,
	input wire logic [31:0] instr_word,
	input wire logic        instr_ready,
	input wire logic [31:0] reg_base,
	input wire logic        mem_req,
	input wire logic        mem_we,
	input wire logic [31:0] mem_addr,
	input wire logic        mem_ack,
	input wire logic        reg_we,
	input wire logic [5:0]  reg_sel,
	input wire logic        fbr_load,
	input wire logic [7:0]  fbr_data,
	input wire logic [7:0]  fbr_value,
	input wire logic        done,
	input wire logic        illegal_instr
);
	// *************
	// word tracking
	// *************
	logic [1:0]  wcnt_r;
	logic [1:0]  wcnt_nxt;
	logic [31:0] w1_r;
	logic [31:0] src_r;
	logic        take;
	logic        bad;
	logic        zero;
	logic        src_reg;
	assign take = instr_valid && instr_ready && ce;
	assign bad = (w1_r[29:24] != 6'h00) || (src_r[1:0] != instr_word[1:0]);
	assign zero = (w1_r[23:0] == 24'h00_0000);
	assign src_reg = (src_r[31:6] == reg_base[31:6]);
	// non-move first words are swallowed, so the count only starts on a move
	always_comb begin
		wcnt_nxt = wcnt_r;
		if (take && wcnt_r == 2'h2) wcnt_nxt = 2'h0;
		else if (take && (wcnt_r != 2'h0 || instr_word[31:30] == move_engine_pkg::TYPE_MOVE)) wcnt_nxt = wcnt_r + 2'h1;
	end
	always_ff @(posedge clk) begin
		wcnt_r <= reset_n ? wcnt_nxt : 2'h0;
		if (take && wcnt_r == 2'h0) w1_r <= instr_word;
		if (take && wcnt_r == 2'h1) src_r <= instr_word;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	sequence s_move_taken;
		take && wcnt_r == 2'h2;
	endsequence
	sequence s_first_read;
		##[1:4] (mem_req && !mem_we && mem_addr[31:2] == src_r[31:2]);
	endsequence
	property p_illegal; s_move_taken and bad |-> ##[1:4] illegal_instr; endproperty
	a_illegal: assert property (p_illegal) else $error("fault not flagged");
	property p_first_read; s_move_taken and !bad && !zero && !src_reg |-> s_first_read; endproperty
	a_first_read: assert property (p_first_read) else $error("first read not at source");
	property p_zero; s_move_taken and !bad && zero |-> !mem_req throughout (##[1:5] done); endproperty
	a_zero: assert property (p_zero) else $error("empty move misbehaved");
	property p_hold; mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we); endproperty
	a_hold: assert property (p_hold) else $error("bus request dropped early");
	property p_refuse; mem_req |-> !instr_ready; endproperty
	a_refuse: assert property (p_refuse) else $error("word accepted while copying");
	property p_no_bus_reg; mem_req |-> mem_addr[31:6] != reg_base[31:6]; endproperty
	a_no_bus_reg: assert property (p_no_bus_reg) else $error("register space sent to bus");
	property p_fbr_protect; reg_we |-> reg_sel != move_engine_pkg::FBR_SEL; endproperty
	a_fbr_protect: assert property (p_fbr_protect) else $error("first byte register written");
	property p_fbr_load; fbr_load && ce |=> fbr_value == $past(fbr_data); endproperty
	a_fbr_load: assert property (p_fbr_load) else $error("first byte load lost");
	property p_fbr_hold; reset_n && !fbr_load |=> $stable(fbr_value); endproperty
	a_fbr_hold: assert property (p_fbr_hold) else $error("first byte changed");
endmodule

bind memory_move_engine memory_move_engine_properties memory_move_engine_properties_i (.clk(clk),
	.reset_n(reset_n), .ce(ce), .instr_valid(instr_valid), .instr_word(instr_word), .instr_ready(instr_ready),
	.reg_base(reg_base), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_ack(mem_ack),
	.reg_we(reg_we), .reg_sel(reg_sel), .fbr_load(fbr_load), .fbr_data(fbr_data), .fbr_value(fbr_value),
	.done(done), .illegal_instr(illegal_instr));

/* File: dv/memory_move_engine_tb_top.sv */
// self-checking bench for the memory move engine
`timescale 1ns/1ps
module memory_move_engine_tb_top;
	logic        clk = 1'b0;
	logic        reset_n = 1'b0;
	logic        instr_valid = 1'b0;
	logic [31:0] instr_word = 32'h0000_0000;
	logic [31:0] reg_base = 32'h4000_0000;
	logic [31:0] reg_rdata = 32'h0000_0000;
	logic        fbr_load = 1'b0;
	logic [7:0]  fbr_data = 8'h00;
	logic        slow = 1'b0;
	logic        ce = 1'b1;
	logic        instr_ready, mem_req, mem_we, mem_ack, reg_we, busy, done, illegal_instr, got_done, got_ill;
	logic [31:0] mem_addr, mem_wdata, mem_rdata, reg_wdata, temp_value, dsb_value, last_wd;
	logic [5:0]  reg_sel, last_sel;
	logic [7:0]  fbr_value;
	logic [15:0] lfsr_r = 16'h673A;
	int          n_errors = 0;
	int          checks_done = 0;
	int          n_req, n_regwr;

	always #2.5 clk = ~clk;

	memory_move_engine memory_move_engine_i (.clk(clk), .reset_n(reset_n), .ce(ce), .instr_valid(instr_valid),
		.instr_word(instr_word), .instr_ready(instr_ready), .reg_base(reg_base), .mem_req(mem_req),
		.mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
		.reg_we(reg_we), .reg_sel(reg_sel), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .fbr_load(fbr_load),
		.fbr_data(fbr_data), .fbr_value(fbr_value), .temp_value(temp_value), .dsb_value(dsb_value),
		.busy(busy), .done(done), .illegal_instr(illegal_instr));
	mem_model mem_model_i (.clk(clk), .slow(slow), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

	always @(posedge clk) begin
		if (mem_req && mem_ack) n_req <= n_req + 1;
		if (reg_we) n_regwr <= n_regwr + 1;
		if (reg_we) last_sel <= reg_sel;
		if (reg_we) last_wd <= reg_wdata;
		if (done) got_done <= 1'b1;
		if (illegal_instr) got_ill <= 1'b1;
	end

	// *******
	// helpers
	// *******
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string msg);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH %0t %s got %h expected %h", $time, msg, got, exp);
		end
	endtask
	task automatic end_of_test;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// valid stays up across the three words, dropped by the caller
	task automatic send(input logic [31:0] w);
		instr_word = w;
		while (!instr_ready) @(negedge clk);
		@(negedge clk);
	endtask
	task automatic run(input logic [31:0] w1, input logic [31:0] s, input logic [31:0] d, input logic ill);
		int n;
		n = 0;
		n_req = 0;
		n_regwr = 0;
		got_done = 1'b0;
		got_ill = 1'b0;
		mem_model_i.wr_mem.delete();
		instr_valid = 1'b1;
		send(w1);
		send(s);
		send(d);
		instr_valid = 1'b0;
		while (!got_done && !got_ill && n < 2000) begin
			@(negedge clk);
			n++;
		end
		repeat (4) @(negedge clk);
		cmp(32'(got_ill), 32'(ill), "illegal instruction flag");
		if (!ill) cmp(32'(got_done), 32'h1, "completion flag");
	endtask
	// short tails round up to a whole word
	task automatic mem_move(input logic [23:0] c, input logic [31:0] s, input logic [31:0] d);
		int nw;
		nw = (int'(c) + 3) / 4;
		run({8'hC0, c}, s, d, 1'b0);
		for (int i = 0; i < nw; i++)
			cmp(mem_model_i.wr_mem[d + 32'(4 * i)], (s + 32'(4 * i)) ^ 32'h5A5A_C3C3, "copied word");
		cmp(32'(mem_model_i.wr_mem.num()), 32'(nw), "words written");
		cmp(32'(n_req), 32'(2 * nw), "bus cycles");
		cmp(dsb_value, d + 32'(4 * nw), "working destination");
		cmp(temp_value, s + 32'(4 * nw), "working source");
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		end_of_test;
	end

	initial begin
		repeat (12) @(negedge clk);
		reset_n = 1'b1;
		instr_valid = 1'b1;
		send(32'h4000_0010);
		instr_valid = 1'b0;
		repeat (4) @(negedge clk);
		cmp(32'(busy), 32'h0, "non-move word started");
		mem_move(24'h00_0001, 32'h0000_1000, 32'h0000_8000);
		mem_move(24'h00_0011, 32'h0000_1100, 32'h0000_8100);
		for (int r = 0; r < 8; r++) begin
			lfsr_r = lfsr_next(lfsr_r);
			slow = lfsr_r[0];
			mem_move(24'(lfsr_r[5:0]) + 24'h00_0001, {20'h00001, lfsr_r[11:2], 2'h0}, {20'h00008, lfsr_r[15:6], 2'h0});
		end
		run(32'hC000_0000, 32'h0000_1000, 32'h0000_8000, 1'b0);
		cmp(32'(n_req), 32'h0, "bus used by empty move");
		for (int b = 24; b < 30; b++) begin
			run(32'hC000_0008 | (32'h1 << b), 32'h0000_1000, 32'h0000_8000, 1'b1);
			cmp(32'(n_req), 32'h0, "bus used by faulty move");
		end
		run(32'hC000_0008, 32'h0000_1001, 32'h0000_8002, 1'b1);
		run(32'hC000_0004, 32'h0000_1000, reg_base | 32'h0000_0015, 1'b1);
		run(32'hC000_0004, 32'h0000_1040, reg_base | 32'h0000_0014, 1'b0);
		cmp(32'(n_regwr), 32'h1, "register writes");
		cmp(32'(last_sel), 32'h14, "register index");
		cmp(last_wd, 32'h0000_1040 ^ 32'h5A5A_C3C3, "register write data");
		lfsr_r = lfsr_next(lfsr_r);
		fbr_data = lfsr_r[7:0];
		fbr_load = 1'b1;
		@(negedge clk);
		fbr_load = 1'b0;
		cmp(32'(fbr_value), 32'(lfsr_r[7:0]), "first byte load");
		// clock enable low must freeze the byte even with a load pending
		ce = 1'b0;
		fbr_data = ~fbr_data;
		fbr_load = 1'b1;
		repeat (2) @(negedge clk);
		fbr_load = 1'b0;
		ce = 1'b1;
		@(negedge clk);
		cmp(32'(fbr_value), 32'(lfsr_r[7:0]), "load while frozen");
		run(32'hC000_0004, 32'h0000_1000, reg_base | 32'(move_engine_pkg::FBR_SEL), 1'b0);
		cmp(32'(n_regwr), 32'h0, "protected register written");
		cmp(32'(fbr_value), 32'(lfsr_r[7:0]), "first byte kept");
		reg_rdata = {lfsr_r, 16'hA5C3};
		run(32'hC000_0004, reg_base | 32'h0000_0020, 32'h0000_8800, 1'b0);
		cmp(mem_model_i.wr_mem[32'h0000_8800], {lfsr_r, 16'hA5C3}, "register saved to memory");
		run(32'hC000_0004, reg_base | 32'(move_engine_pkg::FBR_SEL), 32'h0000_8900, 1'b0);
		cmp(mem_model_i.wr_mem[32'h0000_8900], {24'h00_0000, lfsr_r[7:0]}, "first byte saved");
		end_of_test;
	end
endmodule
